/* verilog/tix_regs.sv */
// tix_regs.sv: external input select, capability id0/id5, trace enable and q element config, AHB-Lite slave
// assumes: one 40 MHz clock, synchronous active-high reset, single whole-word transfers
`timescale 1ns/10ps

// Operation
// - select register frozen while trace enabled
// - select register present only if count nonzero
// - configurable input count, at most 256
// - select register 32-bit read-write, no defined reset
// - field count follows select resource code
// - each field is unsigned input index
// - field width set by input count
// - capability id0 read-only, fixed by build
// - bit 29 reports commit mode
// - bits 28:24 report timestamp width code
// - timestamping implies enable and control register
// - bit 17 reports exception data support
// - q support 00 makes config read zero
// - q support 01 allows config 00/01
// - q support 10 allows 00/11; 11 full
// - bit 14 filtering only when q supported
// - bits 13:12 report conditional trace type
module tix_regs
   import tix_pkg::*;
#(
   parameter int NUM_SEL = 4,
   parameter int NUM_EXTIN = 256,
   parameter bit COMMIT_MODE = 1'b0,
   parameter logic [4:0] TS_SIZE = `TIX_TS_64,
   parameter bit EXDATA_SUPP = 1'b0,
   parameter logic [1:0] Q_SUPP = `TIX_Q_BOTH,
   parameter bit Q_FILT = 1'b1,
   parameter logic [1:0] COND_TYPE = `TIX_COND_PASSFAIL
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [11:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // trace unit view
   output logic trace_enabled_o,
   output logic timestamp_enable_o,
   output logic [1:0] q_element_config_o,
   output logic [31:0] ext_input_choice_o
);

   // ----------------------------------------------------------------------------
   // derived sizes
   // ----------------------------------------------------------------------------
   localparam int SELW = (NUM_EXTIN <= 2) ? 1 : $clog2(NUM_EXTIN);
   localparam logic [2:0] SEL_CODE = 3'(NUM_SEL);
   localparam logic [8:0] EXTIN_CODE = 9'(NUM_EXTIN);
   localparam bit TS_PRESENT = (TS_SIZE != `TIX_TS_NONE);

   initial begin
      if (NUM_SEL < 0 || NUM_SEL > 4) $error("tix_regs: NUM_SEL out of range");
      if (NUM_EXTIN < 1 || NUM_EXTIN > `TIX_MAX_INPUTS) $error("tix_regs: NUM_EXTIN out of range");
      if (TS_SIZE != `TIX_TS_NONE && TS_SIZE != `TIX_TS_48 && TS_SIZE != `TIX_TS_64)
         $error("tix_regs: reserved timestamp size");
      if (COND_TYPE != `TIX_COND_PASSFAIL && COND_TYPE != `TIX_COND_FLAGS)
         $error("tix_regs: reserved conditional type");
   end

   // ----------------------------------------------------------------------------
   // fixed capability words
   // ----------------------------------------------------------------------------
   function automatic logic [31:0] id0_word();
      logic [31:0] w;
      w = 32'h0;
      w[`TIX_ID0_COMMIT_BIT] = COMMIT_MODE;
      w[`TIX_ID0_TS_LSB +: 5] = TS_SIZE;
      w[`TIX_ID0_EXDATA_BIT] = EXDATA_SUPP;
      w[`TIX_ID0_Q_ELEMENT_SUPPORT_CODE_LSB +: 2] = Q_SUPP;
      w[`TIX_ID0_Q_ELEMENT_FILTER_SUPPORT_BIT] = (Q_SUPP != `TIX_Q_NONE) ? Q_FILT : 1'b0;
      w[`TIX_ID0_COND_LSB +: 2] = COND_TYPE;
      return w;
   endfunction : id0_word

   localparam logic [31:0] ID0_VAL = id0_word();

   function automatic logic [31:0] id5_word();
      logic [31:0] w;
      w = 32'h0;
      w[`TIX_ID5_EXTERNAL_INPUT_COUNT_LSB +: 9] = EXTIN_CODE;
      w[`TIX_ID5_NUMSEL_LSB +: 3] = SEL_CODE;
      return w;
   endfunction : id5_word

   localparam logic [31:0] ID5_VAL = id5_word();

   // implemented bits of the select register
   function automatic logic [31:0] sel_mask();
      logic [31:0] m;
      m = 32'h0;
      for (int i = 0; i < 4; i++) begin
         if (i < NUM_SEL) begin
            m[i * `TIX_SEL_W +: `TIX_SEL_W] = 8'((9'h1 << SELW) - 9'h1);
         end
      end
      return m;
   endfunction : sel_mask

   localparam logic [31:0] SEL_MASK = sel_mask();

   // legal q element config per support code
   function automatic logic [1:0] qe_filter(input logic [1:0] v);
      logic [1:0] r;
      r = `TIX_QE_OFF;
      case (Q_SUPP)
         `TIX_Q_NONE: r = `TIX_QE_OFF;
         `TIX_Q_WITH: r = (v == `TIX_QE_ONLY_WITH) ? v : `TIX_QE_OFF;
         `TIX_Q_WITHOUT: r = (v == `TIX_QE_ONLY_WITHOUT) ? v : `TIX_QE_OFF;
         default: r = v;
      endcase
      return r;
   endfunction : qe_filter

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic wr_pend;
      tix_reg_t dreg;
      logic [31:0] rdata;
      logic [31:0] sel;
      logic enabled;
      logic ts_en;
      logic [1:0] qe;
   } tix_state_t;

   tix_state_t s_q;
   tix_state_t s_d;

   logic take;
   tix_reg_t areg;

   always_comb begin
      take = hsel_i && hready_i && (htrans_i == `TIX_HTRANS_NONSEQ);
      case (haddr_i)
         `TIX_OFS_EXTINSEL: areg = (NUM_SEL > 0) ? TIX_REG_EXTINSEL : TIX_REG_NONE;
         `TIX_OFS_ID0: areg = TIX_REG_ID0;
         `TIX_OFS_ID5: areg = TIX_REG_ID5;
         `TIX_OFS_CTRL: areg = TIX_REG_CTRL;
         `TIX_OFS_QECFG: areg = TIX_REG_QECFG;
         default: areg = TIX_REG_NONE;
      endcase
   end

   // ----------------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (s_q.wr_pend) begin
         case (s_q.dreg)
            TIX_REG_EXTINSEL: begin
               if (!s_q.enabled) begin
                  s_d.sel = hwdata_i & SEL_MASK;
               end
            end
            TIX_REG_CTRL: begin
               s_d.enabled = hwdata_i[0];
               s_d.ts_en = TS_PRESENT ? hwdata_i[1] : 1'b0;
            end
            TIX_REG_QECFG: begin
               if (!s_q.enabled) begin
                  s_d.qe = qe_filter(hwdata_i[1:0]);
               end
            end
            default: begin
            end
         endcase
      end
      s_d.wr_pend = take && hwrite_i;
      s_d.dreg = take ? areg : TIX_REG_NONE;
      // reads use the post-write view so a read pipelined behind a write sees the new value
      if (take && !hwrite_i) begin
         case (areg)
            TIX_REG_EXTINSEL: s_d.rdata = s_d.sel & SEL_MASK;
            TIX_REG_ID0: s_d.rdata = ID0_VAL;
            TIX_REG_ID5: s_d.rdata = ID5_VAL;
            TIX_REG_CTRL: s_d.rdata = {30'h0, s_d.ts_en, s_d.enabled};
            TIX_REG_QECFG: s_d.rdata = {30'h0, s_d.qe};
            default: s_d.rdata = 32'h0;
         endcase
      end
   end

   // select contents keep their value through reset and are not cleared: software programs them
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         s_q.wr_pend <= 1'b0;
         s_q.dreg <= TIX_REG_NONE;
         s_q.rdata <= 32'h0;
         s_q.enabled <= 1'b0;
         s_q.ts_en <= 1'b0;
         s_q.qe <= `TIX_QE_OFF;
         s_q.sel <= s_d.sel;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------------
   assign hrdata_o = s_q.rdata;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign trace_enabled_o = s_q.enabled;
   assign timestamp_enable_o = s_q.ts_en;
   assign q_element_config_o = s_q.qe;
   assign ext_input_choice_o = s_q.sel & SEL_MASK;

endmodule : tix_regs

/* verilog/tix_cfg.svh */
// tix_cfg.svh: offsets, field positions and codes for the trace input-select and capability registers
// assumes: included by bare name from the package, the monitor and the bench
`ifndef TIX_CFG_SVH
`define TIX_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets (word aligned)
// ----------------------------------------------------------------------------
`define TIX_OFS_EXTINSEL 12'h000
`define TIX_OFS_ID0 12'h004
`define TIX_OFS_ID5 12'h008
`define TIX_OFS_CTRL 12'h00c
`define TIX_OFS_QECFG 12'h010

// ----------------------------------------------------------------------------
// capability id0 field positions
// ----------------------------------------------------------------------------
`define TIX_ID0_COMMIT_BIT 29
`define TIX_ID0_TS_LSB 24
`define TIX_ID0_EXDATA_BIT 17
`define TIX_ID0_Q_ELEMENT_SUPPORT_CODE_LSB 15
`define TIX_ID0_Q_ELEMENT_FILTER_SUPPORT_BIT 14
`define TIX_ID0_COND_LSB 12

// ----------------------------------------------------------------------------
// capability id5 field positions
// ----------------------------------------------------------------------------
`define TIX_ID5_EXTERNAL_INPUT_COUNT_LSB 0
`define TIX_ID5_NUMSEL_LSB 16

// ----------------------------------------------------------------------------
// codes
// ----------------------------------------------------------------------------
`define TIX_TS_NONE 5'h00
`define TIX_TS_48 5'h06
`define TIX_TS_64 5'h08
`define TIX_Q_NONE 2'h0
`define TIX_Q_WITH 2'h1
`define TIX_Q_WITHOUT 2'h2
`define TIX_Q_BOTH 2'h3
`define TIX_QE_OFF 2'h0
`define TIX_QE_ONLY_WITH 2'h1
`define TIX_QE_ONLY_WITHOUT 2'h3
`define TIX_COND_PASSFAIL 2'h0
`define TIX_COND_FLAGS 2'h1
`define TIX_SEL_W 8
`define TIX_MAX_INPUTS 256
`define TIX_HTRANS_NONSEQ 2'h2
`define TIX_HSIZE_WORD 3'h2

`endif

/* verilog/tix_pkg.sv */
// tix_pkg.sv: types for the trace input-select register bank
// assumes: tix_cfg.svh holds every number
package tix_pkg;
`include "tix_cfg.svh"

   // ----------------------------------------------------------------------------
   // register selector
   // ----------------------------------------------------------------------------
   typedef enum logic [2:0] {
      TIX_REG_NONE,
      TIX_REG_EXTINSEL,
      TIX_REG_ID0,
      TIX_REG_ID5,
      TIX_REG_CTRL,
      TIX_REG_QECFG
   } tix_reg_t;

endpackage : tix_pkg

/* test/tix_regs_monitor.sv */
// tix_regs_monitor.sv: bus-side checker for the trace input-select register bank
// assumes: bound to tix_regs, hready_i tied to hreadyout_o, zero-wait slave
`timescale 1ns/10ps
`include "tix_cfg.svh"
module tix_regs_monitor
   import tix_pkg::*;
#(
   parameter int NUM_SEL = 4,
   parameter int NUM_EXTIN = 256,
   parameter bit COMMIT_MODE = 1'b0,
   parameter logic [4:0] TS_SIZE = `TIX_TS_64,
   parameter bit EXDATA_SUPP = 1'b0,
   parameter logic [1:0] Q_SUPP = `TIX_Q_BOTH,
   parameter bit Q_FILT = 1'b1,
   parameter logic [1:0] COND_TYPE = `TIX_COND_PASSFAIL
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // ahb-lite
   input wire logic hsel_i,
   input wire logic [11:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   // trace unit view
   input wire logic trace_enabled_o,
   input wire logic timestamp_enable_o,
   input wire logic [1:0] q_element_config_o,
   input wire logic [31:0] ext_input_choice_o
);
   localparam int W = (NUM_EXTIN > 1) ? $clog2(NUM_EXTIN) : 1;
   localparam logic [31:0] FM = (32'h1 << W) - 32'h1;
   localparam logic [31:0] MASK = (NUM_SEL > 3 ? FM << 24 : 32'h0) | (NUM_SEL > 2 ? FM << 16 : 32'h0) |
      (NUM_SEL > 1 ? FM << 8 : 32'h0) | (NUM_SEL > 0 ? FM : 32'h0);
   localparam logic [31:0] ID0 = {2'h0, COMMIT_MODE, TS_SIZE, 6'h00, EXDATA_SUPP, Q_SUPP,
      Q_FILT && (Q_SUPP != 2'h0), COND_TYPE, 12'h000};

   // ----------------------------------------------------------------------------
   // transfer taken at an address phase
   // ----------------------------------------------------------------------------
   sequence s_take(logic [11:0] a, logic w);
      hsel_i && hready_i && htrans_i == `TIX_HTRANS_NONSEQ && hwrite_i == w && haddr_i == a;
   endsequence

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   // ----------------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------------
   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not ready or not okay");
   a_sel_frozen: assert property (s_take(`TIX_OFS_EXTINSEL, 1'b1) ##1 trace_enabled_o |=>
      $stable(ext_input_choice_o)) else $error("select changed while tracing");
   a_sel_mask: assert property ((ext_input_choice_o & ~MASK) == 32'h0)
      else $error("unimplemented select bits set");
   a_id0_value: assert property (s_take(`TIX_OFS_ID0, 1'b0) |=> hrdata_o == ID0)
      else $error("capability id0 wrong");
   a_ts_field: assert property (s_take(`TIX_OFS_ID0, 1'b0) |=> hrdata_o[28:24] == TS_SIZE)
      else $error("timestamp width code wrong");
   a_id5_counts: assert property (s_take(`TIX_OFS_ID5, 1'b0) |=> hrdata_o[8:0] == 9'(NUM_EXTIN) &&
      hrdata_o[18:16] == 3'(NUM_SEL)) else $error("input counts wrong");
   a_ts_enable: assert property (s_take(`TIX_OFS_CTRL, 1'b1) |=> ##1
      timestamp_enable_o == ((TS_SIZE != 5'h00) && $past(hwdata_i[1]))) else $error("timestamp enable wrong");
   a_qe_legal: assert property (q_element_config_o == 2'h0 || Q_SUPP == 2'h3 ||
      (Q_SUPP == 2'h1 && q_element_config_o == 2'h1) || (Q_SUPP == 2'h2 && q_element_config_o == 2'h3))
      else $error("illegal q element config");
   a_unmapped_zero: assert property (hsel_i && hready_i && htrans_i == `TIX_HTRANS_NONSEQ && !hwrite_i &&
      haddr_i > 12'h010 |=> hrdata_o == 32'h0) else $error("unmapped read not zero");
endmodule : tix_regs_monitor

bind tix_regs tix_regs_monitor #(.NUM_SEL(NUM_SEL), .NUM_EXTIN(NUM_EXTIN), .COMMIT_MODE(COMMIT_MODE),
   .TS_SIZE(TS_SIZE), .EXDATA_SUPP(EXDATA_SUPP), .Q_SUPP(Q_SUPP), .Q_FILT(Q_FILT), .COND_TYPE(COND_TYPE))
   mon_u (.core_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hwdata_i, .hrdata_o,
   .hreadyout_o, .hresp_o, .trace_enabled_o, .timestamp_enable_o, .q_element_config_o, .ext_input_choice_o);

/* test/tix_regs_tb.sv */
// tix_regs_tb.sv: self-checking bench for the trace input-select register bank
// assumes: a non-default build (3 selectors, 50 inputs), hready_i fed from hreadyout_o
`timescale 1ns/10ps
`include "tix_cfg.svh"
module tix_regs_tb
   import tix_pkg::*;
;
   localparam int NSEL = 3;
   localparam int NEXT = 50;
   // commit 1, 48-bit timestamp, exdata, q without counts, filter, flag tracing
   localparam logic [31:0] ID0 = 32'h2603_5000;
   localparam logic [31:0] ID5 = {13'h0, 3'(NSEL), 7'h0, 9'(NEXT)};
   logic core_clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, hready_i;
   logic [1:0] htrans_i = 2'h0;
   logic [11:0] haddr_i = 12'h000;
   logic [2:0] hsize_i = `TIX_HSIZE_WORD;
   logic [31:0] hwdata_i = 32'h0, hrdata_o, ext_input_choice_o, rd, m_sel, mask = 32'h0, lfsr = 32'h7c67;
   logic hreadyout_o, hresp_o, trace_enabled_o, timestamp_enable_o;
   logic [1:0] q_element_config_o;
   int errors = 0, samples_checked = 0;
   assign hready_i = hreadyout_o;

   tix_regs #(.NUM_SEL(NSEL), .NUM_EXTIN(NEXT), .COMMIT_MODE(1'b1), .TS_SIZE(`TIX_TS_48), .EXDATA_SUPP(1'b1),
      .Q_SUPP(`TIX_Q_WITHOUT), .Q_FILT(1'b1), .COND_TYPE(`TIX_COND_FLAGS)) dut_u (.core_clk_i, .rst_i, .hsel_i,
      .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o,
      .trace_enabled_o, .timestamp_enable_o, .q_element_config_o, .ext_input_choice_o);

   initial begin
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   // ----------------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one single transfer; address phase held until hready, read data taken at the data-phase edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
      hsel_i <= 1'b1;
      htrans_i <= `TIX_HTRANS_NONSEQ;
      hwrite_i <= w;
      haddr_i <= a;
      do @(posedge core_clk_i); while (hready_i !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      do @(posedge core_clk_i); while (hready_i !== 1'b1);
      rd = hrdata_o;
   endtask : bus

   task automatic finish_test;
      if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   // ----------------------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------------------
   initial begin
      for (int i = 0; i < NSEL; i++) mask |= ((32'h1 << $clog2(NEXT)) - 32'h1) << (8 * i);
      repeat (10) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      chk({trace_enabled_o, timestamp_enable_o, q_element_config_o}, 32'h0);
      bus(1'b1, `TIX_OFS_ID0, 32'hffff_ffff); // read-only, write must be dropped
      bus(1'b0, `TIX_OFS_ID0, 32'h0);
      chk(rd, ID0);
      bus(1'b0, `TIX_OFS_ID5, 32'h0);
      chk(rd, ID5);
      bus(1'b0, 12'h020, 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         m_sel = lfsr & mask;
         bus(1'b1, `TIX_OFS_EXTINSEL, lfsr);
         bus(1'b0, `TIX_OFS_EXTINSEL, 32'h0);
         chk(rd, m_sel);
         chk(ext_input_choice_o, m_sel);
      end
      // tracing on: the select write right after must be dropped
      bus(1'b1, `TIX_OFS_CTRL, 32'h1);
      bus(1'b1, `TIX_OFS_EXTINSEL, ~m_sel);
      bus(1'b0, `TIX_OFS_EXTINSEL, 32'h0);
      chk(rd, m_sel);
      chk(ext_input_choice_o, m_sel);
      bus(1'b1, `TIX_OFS_CTRL, 32'h2);
      bus(1'b0, `TIX_OFS_ID0, 32'h0);
      chk({trace_enabled_o, timestamp_enable_o}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, `TIX_OFS_QECFG, 32'(i));
         bus(1'b0, `TIX_OFS_QECFG, 32'h0);
         chk(q_element_config_o, (i == 3) ? 32'h3 : 32'h0);
      end
      finish_test();
   end

   initial begin
      repeat (2000) @(posedge core_clk_i);
      errors++;
      finish_test();
   end
endmodule : tix_regs_tb
